// ---- inc/switch_config_pkg.sv ----
// shared constants and types for the station switch configuration loader
package switch_config_pkg;

    // clock and settling time before the switch levels are trusted
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_NS = 50;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 3;

    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] LIVE_OFS = 8'h08;

    // control register fields
    localparam int CTRL_RESTART_BIT = 0;

    // status register fields
    localparam int ST_ADDR_LSB = 0;
    localparam int ST_FRAME_LSB = 8;
    localparam int ST_RATE_BIT = 16;
    localparam int ST_FRAME_LONG_BIT = 17;
    localparam int ST_ADDR_EN_BIT = 18;
    localparam int ST_READY_BIT = 19;
    localparam int ST_COUNT_LSB = 24;

    // live switch register fields
    localparam int LV_OFFSET_LSB = 0;
    localparam int LV_LINK_LSB = 4;
    localparam int LV_PENDING_BIT = 8;

    // link configuration switch positions
    localparam int SW_RATE = 0;
    localparam int SW_FRAME = 1;
    localparam int SW_BASE = 2;

    // decoded values
    localparam logic [7:0] BASE_LOW = 8'h40;
    localparam logic [7:0] BASE_HIGH = 8'h50;
    localparam logic [7:0] ADDR_DISABLED = 8'h00;
    localparam logic [5:0] FRAME_SHORT = 6'h11;
    localparam logic [5:0] FRAME_LONG = 6'h20;

    // factory default switch settings
    localparam logic [3:0] OFFSET_DEFAULT = 4'h1;
    localparam logic [3:0] LINK_DEFAULT = 4'h3;
    localparam logic [7:0] ADDR_DEFAULT = 8'h41;

    typedef struct packed {
        logic rate_10m;
        logic frame_long;
        logic addr_enable;
        logic [5:0] frame_bytes;
        logic [7:0] station_addr;
    } link_cfg_s;

    localparam link_cfg_s CFG_DEFAULT = '{
        rate_10m: 1'b1,
        frame_long: 1'b1,
        addr_enable: 1'b1,
        frame_bytes: FRAME_LONG,
        station_addr: ADDR_DEFAULT
    };

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_CAPTURE = 3'b010,
        ST_RUN = 3'b100
    } load_state_e;

endpackage

// ---- rtl/switch_pin_sync.sv ----
// two-stage synchroniser for the switch pins, one pair of flops per bit
`timescale 1ns/1ps
module switch_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end
                else
                begin
                    // first stage feeds only the second
                    meta_reg[i] <= pin_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign pin_sync = sync_reg;

endmodule

// ---- rtl/fieldbus_station_switch_config.sv ----
// decodes the two configuration switch banks into the fieldbus link settings
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module fieldbus_station_switch_config (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] address_offset_switches,
    input wire logic [3:0] link_config_switches,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output switch_config_pkg::link_cfg_s link_cfg,
    output logic config_ready
);

    logic [7:0] pins_sync;
    logic [3:0] offset_live;
    logic [3:0] link_live;

    switch_config_pkg::load_state_e state_reg;
    switch_config_pkg::load_state_e state_next;
    logic [switch_config_pkg::CNT_W-1:0] settle_cnt_reg;
    logic [switch_config_pkg::CNT_W-1:0] settle_cnt_next;

    switch_config_pkg::link_cfg_s cfg_reg;
    switch_config_pkg::link_cfg_s cfg_decoded;
    logic [3:0] offset_taken_reg;
    logic [3:0] link_taken_reg;
    logic ready_reg;
    logic [7:0] capture_count_reg;
    logic pending_reg;
    logic [31:0] rdata_reg;

    logic restart_req;
    logic [31:0] status_word;
    logic [31:0] live_word;

    // the switches are mechanical and asynchronous to ref_clk
    switch_pin_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in({link_config_switches, address_offset_switches}),
        .pin_sync(pins_sync)
    );

    assign offset_live = pins_sync[3:0];
    assign link_live = pins_sync[7:4];

    // software restart: reloads the switches just as a hardware restart does
    assign restart_req = reg_wr
        && (reg_addr == switch_config_pkg::CTRL_OFS)
        && reg_wdata[switch_config_pkg::CTRL_RESTART_BIT];

    // decode of the synchronised switch levels
    always_comb
    begin
        logic [7:0] base;
        base = switch_config_pkg::BASE_LOW;
        cfg_decoded = switch_config_pkg::CFG_DEFAULT;
        cfg_decoded.rate_10m = link_live[switch_config_pkg::SW_RATE];
        // the frame switch counts only at the fast rate
        cfg_decoded.frame_long = link_live[switch_config_pkg::SW_RATE]
            && link_live[switch_config_pkg::SW_FRAME];
        if (cfg_decoded.frame_long)
        begin
            cfg_decoded.frame_bytes = switch_config_pkg::FRAME_LONG;
        end
        else
        begin
            cfg_decoded.frame_bytes = switch_config_pkg::FRAME_SHORT;
        end
        if (link_live[switch_config_pkg::SW_BASE])
        begin
            base = switch_config_pkg::BASE_HIGH;
        end
        else
        begin
            base = switch_config_pkg::BASE_LOW;
        end
        // link_live[3] is reserved and deliberately left unread here
        if (!link_live[switch_config_pkg::SW_BASE] && (offset_live == 4'h0))
        begin
            cfg_decoded.addr_enable = 1'b0;
            cfg_decoded.station_addr = switch_config_pkg::ADDR_DISABLED;
        end
        else
        begin
            cfg_decoded.addr_enable = 1'b1;
            // offset bit n carries weight 2**n, so plain binary addition fits
            cfg_decoded.station_addr = base + {4'h0, offset_live};
        end
    end

    // load sequence: let the synchroniser settle, take one snapshot, then hold
    always_comb
    begin
        state_next = state_reg;
        settle_cnt_next = settle_cnt_reg;
        case (state_reg)
            switch_config_pkg::ST_SETTLE:
            begin
                if (settle_cnt_reg == switch_config_pkg::CNT_W'(switch_config_pkg::SETTLE_CYC - 1))
                begin
                    state_next = switch_config_pkg::ST_CAPTURE;
                    settle_cnt_next = '0;
                end
                else
                begin
                    settle_cnt_next = settle_cnt_reg + 1'b1;
                end
            end
            switch_config_pkg::ST_CAPTURE:
            begin
                state_next = switch_config_pkg::ST_RUN;
            end
            switch_config_pkg::ST_RUN:
            begin
                // only a restart leaves this state
                state_next = switch_config_pkg::ST_RUN;
            end
            default:
            begin
                state_next = switch_config_pkg::ST_SETTLE;
                settle_cnt_next = '0;
            end
        endcase
        if (restart_req)
        begin
            state_next = switch_config_pkg::ST_SETTLE;
            settle_cnt_next = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg <= switch_config_pkg::ST_SETTLE;
            settle_cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            settle_cnt_reg <= settle_cnt_next;
        end
    end

    // active configuration: written in the capture state only
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            // factory default stands until the first snapshot, flagged not ready
            cfg_reg <= switch_config_pkg::CFG_DEFAULT;
            offset_taken_reg <= switch_config_pkg::OFFSET_DEFAULT;
            link_taken_reg <= switch_config_pkg::LINK_DEFAULT;
        end
        else if (state_reg == switch_config_pkg::ST_CAPTURE)
        begin
            cfg_reg <= cfg_decoded;
            offset_taken_reg <= offset_live;
            link_taken_reg <= link_live;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ready_reg <= 1'b0;
        end
        else if (restart_req)
        begin
            ready_reg <= 1'b0;
        end
        else if (state_reg == switch_config_pkg::ST_CAPTURE)
        begin
            ready_reg <= 1'b1;
        end
    end

    // counts snapshots since the hardware reset; wraps after 255
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            capture_count_reg <= 8'h00;
        end
        else if (state_reg == switch_config_pkg::ST_CAPTURE)
        begin
            capture_count_reg <= capture_count_reg + 8'h01;
        end
    end

    // tells software the switches were moved after the last snapshot;
    // the reserved switch is compared too so a moved one is noticed
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pending_reg <= 1'b0;
        end
        else if (state_reg == switch_config_pkg::ST_RUN)
        begin
            pending_reg <= (offset_live != offset_taken_reg) || (link_live != link_taken_reg);
        end
        else
        begin
            pending_reg <= 1'b0;
        end
    end

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[switch_config_pkg::ST_ADDR_LSB +: 8] = cfg_reg.station_addr;
        status_word[switch_config_pkg::ST_FRAME_LSB +: 6] = cfg_reg.frame_bytes;
        status_word[switch_config_pkg::ST_RATE_BIT] = cfg_reg.rate_10m;
        status_word[switch_config_pkg::ST_FRAME_LONG_BIT] = cfg_reg.frame_long;
        status_word[switch_config_pkg::ST_ADDR_EN_BIT] = cfg_reg.addr_enable;
        status_word[switch_config_pkg::ST_READY_BIT] = ready_reg;
        status_word[switch_config_pkg::ST_COUNT_LSB +: 8] = capture_count_reg;
    end

    always_comb
    begin
        live_word = 32'h0000_0000;
        live_word[switch_config_pkg::LV_OFFSET_LSB +: 4] = offset_live;
        live_word[switch_config_pkg::LV_LINK_LSB +: 4] = link_live;
        live_word[switch_config_pkg::LV_PENDING_BIT] = pending_reg;
    end

    // read data stand for exactly the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                switch_config_pkg::CTRL_OFS:
                begin
                    // restart bit is self-clearing and reads back as zero
                    rdata_reg <= 32'h0000_0000;
                end
                switch_config_pkg::STATUS_OFS:
                begin
                    rdata_reg <= status_word;
                end
                switch_config_pkg::LIVE_OFS:
                begin
                    rdata_reg <= live_word;
                end
                default:
                begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end
        else
        begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;
    assign link_cfg = cfg_reg;
    assign config_ready = ready_reg;

endmodule

// ---- bench/switch_bank_model.sv ----
// model of the two switch banks as the user sets them
`timescale 1ns/1ps
module switch_bank_model (
    input wire logic [3:0] offset_set,
    input wire logic [2:0] link_set,
    output logic [3:0] address_offset_switches,
    output logic [3:0] link_config_switches
);
    assign address_offset_switches = offset_set;
    // the reserved switch is always left off by the user
    assign link_config_switches = {1'b0, link_set};
endmodule

// ---- bench/switch_config_properties.sv ----
// concurrent checks on the switch configuration loader ports
`timescale 1ns/1ps
module switch_config_properties (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire switch_config_pkg::link_cfg_s link_cfg,
    input wire logic config_ready
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    reset_defaults_a: assert property (disable iff (1'b0)
        reset |=> link_cfg == switch_config_pkg::CFG_DEFAULT && !config_ready) else $error("bad reset defaults");
    frame_length_a: assert property (link_cfg.frame_bytes == (link_cfg.frame_long ? 6'h20 : 6'h11))
        else $error("frame length mismatch");
    slow_short_a: assert property (link_cfg.frame_long |-> link_cfg.rate_10m)
        else $error("long frame at slow rate");
    addr_disable_a: assert property (!link_cfg.addr_enable |-> link_cfg.station_addr == 8'h00)
        else $error("disabled address not zero");
    addr_base_a: assert property (link_cfg.addr_enable |-> link_cfg.station_addr inside {[8'h41:8'h5f]})
        else $error("station address out of range");
    config_hold_a: assert property (config_ready && $past(config_ready) |-> $stable(link_cfg))
        else $error("configuration changed while running");
    startup_time_a: assert property ($fell(reset) |-> !config_ready [*6] ##1 config_ready)
        else $error("startup capture timing wrong");
    restart_time_a: assert property (reg_wr && reg_addr == switch_config_pkg::CTRL_OFS && reg_wdata[0]
        |=> !config_ready [*6] ##1 config_ready) else $error("restart capture timing wrong");
    status_mirror_a: assert property (reg_rd && reg_addr == switch_config_pkg::STATUS_OFS
        |=> {reg_rdata[19], reg_rdata[16], reg_rdata[17], reg_rdata[18], reg_rdata[13:0]}
        == {$past(config_ready), $past(link_cfg)})
        else $error("status word does not mirror settings");
endmodule

bind fieldbus_station_switch_config switch_config_properties props (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_cfg(link_cfg), .config_ready(config_ready));

// ---- bench/tb_top.sv ----
// self-checking bench for the switch configuration loader
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    switch_config_pkg::link_cfg_s link_cfg;
    logic config_ready;
    logic [3:0] offset_set = 4'h1;
    logic [2:0] link_set = 3'h3;
    logic [3:0] address_offset_switches;
    logic [3:0] link_config_switches;
    logic [31:0] exp_q[$];
    // expected snapshot for each rise of config_ready, oldest first
    logic [16:0] cfg_q[$];
    logic ready_seen = 1'b0;
    logic rd_pend = 1'b0;
    logic [7:0] cap_cnt = 8'h0;
    logic [3:0] old_off;
    logic [2:0] old_link;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #5 ref_clk = ~ref_clk;

    switch_bank_model bank (.offset_set(offset_set), .link_set(link_set),
        .address_offset_switches(address_offset_switches), .link_config_switches(link_config_switches));

    fieldbus_station_switch_config dut (.ref_clk(ref_clk), .reset(reset),
        .address_offset_switches(address_offset_switches), .link_config_switches(link_config_switches),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_cfg(link_cfg), .config_ready(config_ready));

    function automatic logic [31:0] exp_status(input logic [3:0] off, input logic [2:0] ln, input logic [7:0] cnt);
        logic lng;
        logic en;
        logic [7:0] a;
        lng = ln[0] & ln[1];
        en = ln[2] | (off != 4'h0);
        a = en ? ((ln[2] ? 8'h50 : 8'h40) + {4'h0, off}) : 8'h00;
        return {cnt, 4'h0, 1'b1, en, lng, ln[0], 2'h0, (lng ? 6'h20 : 6'h11), a};
    endfunction

    function automatic logic [16:0] exp_cfg(input logic [3:0] off, input logic [2:0] ln);
        logic lng;
        logic en;
        lng = ln[0] & ln[1];
        en = ln[2] | (off != 4'h0);
        return {ln[0], lng, en, (lng ? 6'h20 : 6'h11), (en ? ((ln[2] ? 8'h50 : 8'h40) + {4'h0, off}) : 8'h00)};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    // the expectation is queued before the strobe so the watcher always finds it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask

    // switch values are passed in: the caller's non-blocking updates have not landed yet
    task automatic restart(input logic [3:0] off, input logic [2:0] ln);
        cfg_q.push_back(exp_cfg(off, ln));
        wr(switch_config_pkg::CTRL_OFS, $urandom | 32'h1);
        repeat (8) @(posedge ref_clk);
        cap_cnt++;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (rd_pend)
        begin
            if (exp_q.size() == 0)
                check("read queue", 32'h1, 32'h0);
            else
                check("reg_rdata", reg_rdata, exp_q.pop_front());
        end
        rd_pend <= reg_rd && !reset;
        if (config_ready === 1'b1 && ready_seen === 1'b0)
        begin
            if (cfg_q.size() == 0)
                check("config queue", 32'h1, 32'h0);
            else
                check("link_cfg", {15'h0, link_cfg}, {15'h0, cfg_q.pop_front()});
        end
        ready_seen <= config_ready;
        if (cycles >= 4000)
        begin
            err_count++;
            complete_run();
        end
    end

    initial
    begin
        void'($urandom(32'h06f8b2f3));
        cfg_q.push_back(exp_cfg(4'h1, 3'h3));
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        cap_cnt = 8'h1;
        rd(switch_config_pkg::STATUS_OFS, exp_status(4'h1, 3'h3, cap_cnt));
        // every offset with every base, rate and frame setting
        for (int i = 0; i < 128; i++)
        begin
            offset_set <= i[3:0];
            link_set <= i[6:4];
            restart(i[3:0], i[6:4]);
            rd(switch_config_pkg::STATUS_OFS, exp_status(i[3:0], i[6:4], cap_cnt));
        end
        old_off = offset_set;
        old_link = link_set;
        offset_set <= old_off ^ 4'($urandom_range(15, 1));
        link_set <= 3'($urandom);
        repeat (4) @(posedge ref_clk);
        rd(switch_config_pkg::STATUS_OFS, exp_status(old_off, old_link, cap_cnt));
        rd(switch_config_pkg::LIVE_OFS, {23'h0, 1'b1, 1'b0, link_set, offset_set});
        wr(switch_config_pkg::CTRL_OFS, 32'hfffffffe);
        wr(switch_config_pkg::STATUS_OFS, 32'hffffffff);
        wr(8'h0c, 32'h1);
        rd(8'h0c, 32'h0);
        rd(switch_config_pkg::CTRL_OFS, 32'h0);
        rd(switch_config_pkg::STATUS_OFS, exp_status(old_off, old_link, cap_cnt));
        restart(offset_set, link_set);
        rd(switch_config_pkg::STATUS_OFS, exp_status(offset_set, link_set, cap_cnt));
        // a second reset in mid-run retakes the switches and clears the count
        offset_set <= 4'h0;
        link_set <= 3'h1;
        cfg_q.push_back(exp_cfg(4'h0, 3'h1));
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        cap_cnt = 8'h1;
        rd(switch_config_pkg::STATUS_OFS, exp_status(4'h0, 3'h1, cap_cnt));
        // switches match the snapshot, so nothing is pending
        rd(switch_config_pkg::LIVE_OFS, {23'h0, 1'b0, 4'h1, 4'h0});
        repeat (2) @(posedge ref_clk);
        complete_run();
    end
endmodule
